// *** logic/dfa_pkg.sv ***
// constants and types shared by the full address dma channel
package dfa_pkg;
  localparam int unsigned AXI_ADDR_W   = 8;             // byte address width of the register window
  // register byte offsets on the bus
  localparam logic [7:0]  OFS_SRC_ADDR = 8'h00;         // source_address
  localparam logic [7:0]  OFS_DST_ADDR = 8'h04;         // dest_address
  localparam logic [7:0]  OFS_COUNT_A  = 8'h08;         // transfer_count_a
  localparam logic [7:0]  OFS_COUNT_B  = 8'h0C;         // transfer_count_b
  localparam logic [7:0]  OFS_CTRL_A   = 8'h10;         // channel_control_a
  localparam logic [7:0]  OFS_CTRL_B   = 8'h14;         // channel_control_b
  localparam logic [7:0]  OFS_STATUS   = 8'h18;         // read-only channel state
  localparam logic [7:0]  CTRL_RESET   = 8'h00;         // both control registers after reset or standby
  // channel_control_a fields
  localparam int unsigned CA_ENABLE    = 7;             // channel_enable
  localparam int unsigned CA_SIZE      = 6;             // size_select
  localparam int unsigned CA_SRC_DIR   = 5;             // src_step_dir
  localparam int unsigned CA_SRC_EN    = 4;             // src_step_en
  localparam int unsigned CA_IRQ_EN    = 3;             // end_irq_enable
  localparam int unsigned CA_FULL_HI   = 2;             // full_mode_sel_hi
  localparam int unsigned CA_FULL_LO   = 1;             // full_mode_sel_lo
  localparam int unsigned CA_BLOCK     = 0;             // block_mode_select
  // channel_control_b fields
  localparam int unsigned CB_MASTER    = 7;             // master_enable
  localparam int unsigned CB_RSVD      = 6;             // reserved, plain storage
  localparam int unsigned CB_DST_DIR   = 5;             // dst_step_dir
  localparam int unsigned CB_DST_EN    = 4;             // dst_step_en
  localparam int unsigned CB_BLOCK_SRC = 3;             // block area is the source when set
  // trigger select codes
  localparam logic [2:0]  TRG_BURST    = 3'h0;          // normal: auto-request, burst
  localparam logic [2:0]  TRG_STEAL    = 3'h2;          // normal: auto-request, cycle steal
  localparam logic [2:0]  TRG_PIN_FALL = 3'h6;          // falling edge of ext_request_pin
  localparam logic [2:0]  TRG_PIN_LOW  = 3'h7;          // normal: low level of ext_request_pin
  localparam logic [2:0]  TRG_TIMER_HI = 3'h3;          // block: highest timer_unit match code
  // address steps
  localparam logic [31:0] STEP_BYTE    = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD    = 32'h0000_0002;
  // bus answers
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // channel sequencer states
  typedef enum logic [1:0] {
    DFA_ST_IDLE = 2'b01,
    DFA_ST_MOVE = 2'b10
  } dfa_state_t;
endpackage : dfa_pkg

// *** logic/dfa_trigger.sv ***
// activation request logic of the channel: pin synchroniser, edge latch, timer select
module dfa_trigger (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_pin,           // ext_request_pin, asynchronous
  input  wire logic [3:0] i_timer_match,   // one-cycle timer_unit compare pulses, same clock
  input  wire logic [2:0] i_sel,           // trigger select code
  input  wire logic       i_block,         // block transfer mode
  input  wire logic       i_accept,        // channel_enable: requests count only when set
  input  wire logic       i_take,          // sequencer consumed the pending request
  output logic            o_request        // a request is available
);
  import dfa_pkg::*;

  logic       sync1_q;                     // first stage, read only by sync2_q
  logic       sync2_q;                     // synchronised pin level
  logic       prev_q;                      // last synchronised level for edge detection
  logic       pend_q;                      // latched edge or timer event
  logic       pend_d;
  wire        pin_fall  = prev_q & ~sync2_q;
  wire        timer_sel = i_block && (i_sel <= TRG_TIMER_HI);
  wire        timer_hit = timer_sel && i_timer_match[i_sel[1:0]];
  wire        edge_sel  = (i_sel == TRG_PIN_FALL);
  wire        auto_sel  = !i_block && ((i_sel == TRG_BURST) || (i_sel == TRG_STEAL));
  wire        low_sel   = !i_block && (i_sel == TRG_PIN_LOW);
  wire        event_hit = i_accept && ((edge_sel && pin_fall) || timer_hit);
  wire        req_now   = auto_sel || (low_sel && !sync2_q) || pend_q;

  // a new event in the cycle of the take is kept, so no request is lost
  assign pend_d = event_hit ? 1'b1 : ((i_take || !i_accept) ? 1'b0 : pend_q);

  // pin passes two flip-flops before any logic looks at it
  always_ff @(posedge i_clock) begin
    sync1_q <= i_pin;
    sync2_q <= sync1_q;
    if (i_rst) begin
      prev_q    <= 1'b1;
      pend_q    <= 1'b0;
      o_request <= 1'b0;
    end else begin
      prev_q    <= sync2_q;
      pend_q    <= pend_d;
      o_request <= req_now && i_accept && !i_take;
    end
  end
endmodule // dfa_trigger

// *** logic/dfa_channel.sv ***
// full address dma channel with axi4-lite register slave
module dfa_channel (
  input  wire logic                             i_clock,
  input  wire logic                             i_rst,
  input  wire logic                             i_standby,       // standby entry, same clock
  input  wire logic                             i_nmi,           // non-maskable interrupt pulse
  input  wire logic                             i_ext_request_pin, // asynchronous request pin
  input  wire logic [3:0]                       i_timer_match,   // timer_unit compare pulses
  input  wire logic                             i_bus_preempt,   // higher priority master wants bus
  input  wire logic                             i_xfer_done,     // system bus finished current move
  output logic                                  o_xfer_valid,    // a move is requested
  output logic [31:0]                           o_xfer_src,      // source byte address
  output logic [31:0]                           o_xfer_dst,      // destination byte address
  output logic                                  o_xfer_word,     // 1 word, 0 byte
  output logic                                  o_bus_hold,      // keep bus between moves
  output logic                                  o_transfer_end_irq, // one-cycle pulse
  input  wire logic [dfa_pkg::AXI_ADDR_W-1:0]   i_awaddr,
  input  wire logic                             i_awvalid,
  output logic                                  o_awready,
  input  wire logic [31:0]                      i_wdata,
  input  wire logic [3:0]                       i_wstrb,
  input  wire logic                             i_wvalid,
  output logic                                  o_wready,
  output logic [1:0]                            o_bresp,
  output logic                                  o_bvalid,
  input  wire logic                             i_bready,
  input  wire logic [dfa_pkg::AXI_ADDR_W-1:0]   i_araddr,
  input  wire logic                             i_arvalid,
  output logic                                  o_arready,
  output logic [31:0]                           o_rdata,
  output logic [1:0]                            o_rresp,
  output logic                                  o_rvalid,
  input  wire logic                             i_rready
);
  import dfa_pkg::*;

  // merge written bytes into an old word under the byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // next address: hold, +step or -step depending on enable and direction
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic en,
                                            input logic dir, input logic word);
    logic [31:0] s;
    s = word ? STEP_WORD : STEP_BYTE;
    if (!en) begin
      return a;
    end
    return dir ? (a - s) : (a + s);
  endfunction

  // register offset decode, used by both read and write paths
  function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
    return (a == OFS_SRC_ADDR) || (a == OFS_DST_ADDR) || (a == OFS_COUNT_A) ||
           (a == OFS_COUNT_B) || (a == OFS_CTRL_A) || (a == OFS_CTRL_B) || (a == OFS_STATUS);
  endfunction

  // ---------------- storage ----------------
  logic [31:0]           src_q, src_d;       // source_address, not reset
  logic [31:0]           dst_q, dst_d;       // dest_address, not reset
  logic [15:0]           cnt_a_q, cnt_a_d;   // transfer_count_a, not reset
  logic [15:0]           cnt_b_q, cnt_b_d;   // transfer_count_b, not reset
  logic [31:0]           blk_start_q;        // block area start for restore
  logic [7:0]            ctl_a_q, ctl_a_d;   // channel_control_a
  logic [7:0]            ctl_b_q, ctl_b_d;   // channel_control_b
  logic                  arm_a_q, arm_a_d;   // control_a read while enable was zero
  logic                  arm_b_q, arm_b_d;   // control_b read while master was zero
  logic                  in_block_q;         // a block is under way
  dfa_state_t            state_q, state_d;
  logic                  irq_q;

  // ---------------- bus slave state ----------------
  logic                  aw_full_q;          // write address held
  logic                  w_full_q;           // write data held
  logic                  awready_q;          // write address ready, registered
  logic                  wready_q;           // write data ready, registered
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  // ---------------- decode ----------------
  wire        aw_hs      = i_awvalid && awready_q;
  wire        w_hs       = i_wvalid && wready_q;
  wire        wr_fire    = aw_full_q && w_full_q && !bvalid_q;
  // next holding state, so both readies can leave from flops
  wire        aw_full_n  = !wr_fire && (aw_full_q || aw_hs);
  wire        w_full_n   = !wr_fire && (w_full_q || w_hs);
  wire        bvalid_n   = wr_fire || (bvalid_q && !i_bready);
  wire        ar_hs      = i_arvalid && arready_q;
  wire        wr_src     = wr_fire && (aw_addr_q == OFS_SRC_ADDR);
  wire        wr_dst     = wr_fire && (aw_addr_q == OFS_DST_ADDR);
  wire        wr_cnt_a   = wr_fire && (aw_addr_q == OFS_COUNT_A);
  wire        wr_cnt_b   = wr_fire && (aw_addr_q == OFS_COUNT_B);
  wire        wr_ctl_a   = wr_fire && (aw_addr_q == OFS_CTRL_A) && w_strb_q[0];
  wire        wr_ctl_b   = wr_fire && (aw_addr_q == OFS_CTRL_B) && w_strb_q[0];
  wire        rd_ctl_a   = ar_hs && (i_araddr == OFS_CTRL_A);
  wire        rd_ctl_b   = ar_hs && (i_araddr == OFS_CTRL_B);
  wire [7:0]  wbyte      = w_data_q[7:0];

  // control fields
  wire        ch_enable  = ctl_a_q[CA_ENABLE];
  wire        word_mode  = ctl_a_q[CA_SIZE];
  wire        full_mode  = ctl_a_q[CA_FULL_HI] && ctl_a_q[CA_FULL_LO];
  wire        block_mode = ctl_a_q[CA_BLOCK];
  wire        mst_enable = ctl_b_q[CB_MASTER];
  wire [2:0]  trig_sel   = ctl_b_q[2:0];
  wire        blk_is_src = ctl_b_q[CB_BLOCK_SRC];
  wire        running    = ch_enable && mst_enable && full_mode;
  wire        burst_sel  = !block_mode && (trig_sel == TRG_BURST);

  // ---------------- sequencer decode ----------------
  wire        req;
  wire        moving     = (state_q == DFA_ST_MOVE);
  wire        moved      = moving && i_xfer_done;
  wire [7:0]  hi_dec     = cnt_a_q[15:8] - 8'h01;
  wire        blk_end    = block_mode && (hi_dec == 8'h00);
  wire        last_norm  = !block_mode && (cnt_a_q == 16'h0001);
  wire        last_blk   = blk_end && (cnt_b_q == 16'h0001);
  wire        finish     = moved && (last_norm || last_blk);
  wire        start      = (state_q == DFA_ST_IDLE) && running && (in_block_q || req);
  wire        take       = start && !in_block_q;
  wire        stay       = running && !finish && (block_mode ? !blk_end : burst_sel);
  wire        stdby_clr  = i_rst || i_standby;

  // addresses after one move, with block area restored at block end
  wire [31:0] src_step   = step_addr(src_q, ctl_a_q[CA_SRC_EN], ctl_a_q[CA_SRC_DIR], word_mode);
  wire [31:0] dst_step   = step_addr(dst_q, ctl_b_q[CB_DST_EN], ctl_b_q[CB_DST_DIR], word_mode);
  wire [31:0] src_move   = (blk_end && blk_is_src) ? blk_start_q : src_step;
  wire [31:0] dst_move   = (blk_end && !blk_is_src) ? blk_start_q : dst_step;

  // trigger source: pin, timer events, auto-request
  dfa_trigger u_trigger (
    .i_clock       (i_clock),
    .i_rst         (stdby_clr),
    .i_pin         (i_ext_request_pin),
    .i_timer_match (i_timer_match),
    .i_sel         (trig_sel),
    .i_block       (block_mode),
    .i_accept      (ch_enable),
    .i_take        (take),
    .o_request     (req)
  );

  // merged count words; a function result cannot be sliced directly
  wire [31:0] cnt_a_m    = merge_strb({16'h0000, cnt_a_q}, w_data_q, w_strb_q);
  wire [31:0] cnt_b_m    = merge_strb({16'h0000, cnt_b_q}, w_data_q, w_strb_q);

  // software writes win over counting in the same cycle
  assign src_d = wr_src ? merge_strb(src_q, w_data_q, w_strb_q) : (moved ? src_move : src_q);
  assign dst_d = wr_dst ? merge_strb(dst_q, w_data_q, w_strb_q) : (moved ? dst_move : dst_q);
  assign cnt_a_d = wr_cnt_a ? cnt_a_m[15:0] :
                   !moved ? cnt_a_q :
                   !block_mode ? (cnt_a_q - 16'h0001) :
                   blk_end ? {cnt_a_q[7:0], cnt_a_q[7:0]} : {hi_dec, cnt_a_q[7:0]};
  assign cnt_b_d = wr_cnt_b ? cnt_b_m[15:0] :
                   (moved && blk_end) ? (cnt_b_q - 16'h0001) : cnt_b_q;

  // control_a: enable set only if armed by a read, self-clear on finish
  wire        ca_set     = wbyte[CA_ENABLE] && (ch_enable || arm_a_q);
  assign ctl_a_d = finish ? {1'b0, ctl_a_q[6:0]} :
                   wr_ctl_a ? {ca_set, wbyte[6:0]} : ctl_a_q;
  // control_b: master set only if armed by a read, nmi clears it
  wire        cb_set     = wbyte[CB_MASTER] && (mst_enable || arm_b_q);
  wire [7:0]  ctl_b_w    = wr_ctl_b ? {cb_set, wbyte[6:0]} : ctl_b_q;
  assign ctl_b_d = i_nmi ? {1'b0, ctl_b_w[6:0]} : ctl_b_w;
  assign arm_a_d = rd_ctl_a ? !ch_enable : (wr_ctl_a ? 1'b0 : arm_a_q);
  assign arm_b_d = rd_ctl_b ? !mst_enable : (wr_ctl_b ? 1'b0 : arm_b_q);

  // sequencer next state; a started move completes before stopping, unless reset or standby clears it
  always_comb begin
    state_d = state_q;
    case (state_q)
      DFA_ST_IDLE: begin
        if (start) begin
          state_d = DFA_ST_MOVE;
        end
      end
      DFA_ST_MOVE: begin
        if (moved && !stay) begin
          state_d = DFA_ST_IDLE;
        end
      end
      default: begin
        state_d = DFA_ST_IDLE;
      end
    endcase
  end

  // read data select; short io address has no register here
  wire [31:0] status_w   = {28'h000_0000, in_block_q, full_mode, running, moving};
  wire [31:0] rd_mux     = (i_araddr == OFS_SRC_ADDR) ? src_q :
                           (i_araddr == OFS_DST_ADDR) ? dst_q :
                           (i_araddr == OFS_COUNT_A)  ? {16'h0000, cnt_a_q} :
                           (i_araddr == OFS_COUNT_B)  ? {16'h0000, cnt_b_q} :
                           (i_araddr == OFS_CTRL_A)   ? {24'h00_0000, ctl_a_q} :
                           (i_araddr == OFS_CTRL_B)   ? {24'h00_0000, ctl_b_q} :
                           (i_araddr == OFS_STATUS)   ? status_w : 32'h0000_0000;

  // address and count data: no reset, they keep their last value
  always_ff @(posedge i_clock) begin
    src_q   <= src_d;
    dst_q   <= dst_d;
    cnt_a_q <= cnt_a_d;
    cnt_b_q <= cnt_b_d;
    if (start && !in_block_q) begin
      blk_start_q <= blk_is_src ? src_q : dst_q;
    end
  end

  // control registers and sequencer; standby clears like reset
  always_ff @(posedge i_clock) begin
    if (stdby_clr) begin
      ctl_a_q    <= CTRL_RESET;
      ctl_b_q    <= CTRL_RESET;
      arm_a_q    <= 1'b0;
      arm_b_q    <= 1'b0;
      in_block_q <= 1'b0;
      state_q    <= DFA_ST_IDLE;
      irq_q      <= 1'b0;
    end else begin
      ctl_a_q    <= ctl_a_d;
      ctl_b_q    <= ctl_b_d;
      arm_a_q    <= arm_a_d;
      arm_b_q    <= arm_b_d;
      state_q    <= state_d;
      // block stays open across an nmi pause so it resumes without a new request
      in_block_q <= (moved && (blk_end || finish)) ? 1'b0 :
                    (start && block_mode) ? 1'b1 : in_block_q;
      irq_q      <= ctl_a_q[CA_IRQ_EN] && ch_enable && !ctl_a_d[CA_ENABLE];
    end
  end

  // move request outputs, registered
  always_ff @(posedge i_clock) begin
    if (stdby_clr) begin
      o_xfer_valid <= 1'b0;
      o_xfer_src   <= 32'h0000_0000;
      o_xfer_dst   <= 32'h0000_0000;
      o_xfer_word  <= 1'b0;
      o_bus_hold   <= 1'b0;
    end else begin
      o_xfer_valid <= (state_d == DFA_ST_MOVE);
      o_xfer_src   <= src_d;
      o_xfer_dst   <= dst_d;
      o_xfer_word  <= ctl_a_d[CA_SIZE];
      o_bus_hold   <= (state_d == DFA_ST_MOVE) && burst_sel && !i_bus_preempt;
    end
  end

  // axi write channels: address and data taken in either order
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      // readies rise one cycle after reset, then follow the holding state
      awready_q <= !aw_full_n && !bvalid_n;
      wready_q  <= !w_full_n && !bvalid_n;
      if (aw_hs) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (w_hs) begin
        w_full_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(aw_addr_q) && (aw_addr_q != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi read channel: one read at a time, data captured at the handshake
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign o_awready          = awready_q;
  assign o_wready           = wready_q;
  assign o_bvalid           = bvalid_q;
  assign o_bresp            = bresp_q;
  assign o_arready          = arready_q;
  assign o_rvalid           = rvalid_q;
  assign o_rdata            = rdata_q;
  assign o_rresp            = rresp_q;
  assign o_transfer_end_irq = irq_q;
endmodule // dfa_channel

// *** verification/dfa_channel_sva.sv ***
// assertion checker bound to the full address dma channel
module dfa_channel_sva (
  input wire logic        i_clock, i_rst, i_standby, i_bus_preempt, i_xfer_done,
  input wire logic        i_awvalid, i_wvalid, i_arvalid,
  input wire logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid,
  input wire logic        o_xfer_valid, o_xfer_word, o_bus_hold, o_transfer_end_irq,
  input wire logic [1:0]  o_rresp,
  input wire logic [31:0] o_xfer_src, o_xfer_dst
);
  import dfa_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // a write with both halves taken together is answered two edges later
  property p_wr_ans; i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_rd_ans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  // no second read is taken while an answer stands
  property p_rd_one; o_rvalid |-> !o_arready; endproperty
  a_rd_one: assert property (p_rd_one) else $error("read taken during answer");
  property p_irq; o_transfer_end_irq |=> !o_transfer_end_irq; endproperty
  a_irq: assert property (p_irq) else $error("end interrupt longer than a pulse");
  // a standing move keeps its addresses until the bus finishes it
  property p_mv; o_xfer_valid && !i_xfer_done && !i_standby |=> o_xfer_valid && $stable(o_xfer_src)
    && $stable(o_xfer_dst); endproperty
  a_mv: assert property (p_mv) else $error("move changed before done");
  property p_word; o_xfer_valid && !i_xfer_done && !i_standby |=> $stable(o_xfer_word); endproperty
  a_word: assert property (p_word) else $error("move size changed");
  property p_pre; i_bus_preempt |=> !o_bus_hold; endproperty
  a_pre: assert property (p_pre) else $error("bus kept against a higher master");
  property p_stby; i_standby |=> !o_xfer_valid && !o_bus_hold; endproperty
  a_stby: assert property (p_stby) else $error("standby left the channel moving");
  cover property (o_transfer_end_irq);
  cover property (o_bus_hold && o_xfer_valid);
  cover property (o_rvalid && o_rresp == RESP_SLVERR);
endmodule // dfa_channel_sva
bind dfa_channel dfa_channel_sva u_sva (.*);

// *** verification/dfa_bus_model.sv ***
// system bus and request source model facing the channel
module dfa_bus_model (
  input  wire logic i_clock, i_rst, i_xfer_valid,
  output logic      o_xfer_done, o_pin, o_preempt,
  output logic [3:0] o_timer_match
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q; // phase counter, makes the answer wait vary
  // done answers only a standing move, never twice in a row
  always_ff @(posedge i_clock) begin
    cnt_q <= i_rst ? 4'h0 : cnt_q + 4'h1;
    o_xfer_done <= !i_rst && i_xfer_valid && !o_xfer_done && cnt_q[0];
  end
  assign o_pin         = cnt_q[3];                  // falls every 16 cycles, low half the time
  assign o_timer_match = {3'h0, cnt_q == 4'hF};     // timer channel 0 match pulse
  assign o_preempt     = cnt_q == 4'h9;             // higher master knocks now and then
endmodule // dfa_bus_model

// *** verification/tb_dfa_channel.sv ***
// register level testbench of the full address dma channel
module tb_dfa_channel;
  timeunit 1ns;
  timeprecision 1ps;
  import dfa_pkg::*;
  logic i_clock = 0, i_rst = 1, i_standby = 0, i_nmi = 0, i_awvalid = 0, i_wvalid = 0;
  logic i_bready = 0, i_arvalid = 0, i_rready = 0, i_xfer_done, i_ext_request_pin, i_bus_preempt;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF, i_timer_match;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_xfer_valid, o_xfer_word, o_bus_hold;
  logic o_transfer_end_irq;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, o_xfer_src, o_xfer_dst;
  int errors = 0, checks_done = 0, moves = 0, irqs = 0, cyc = 0, m0, i0, holds = 0, h0;
  logic [7:0] ca_now = 8'h00; // control_a of the running test, for the move size check
  // legal trigger codes only: burst, steal, pin fall, pin low, block timer 0
  localparam logic [7:0]  CA [5] = '{8'hDE, 8'h8E, 8'hBE, 8'h8E, 8'h9F};
  localparam logic [7:0]  CB [5] = '{8'hB0, 8'h92, 8'h86, 8'h97, 8'h90};
  localparam logic [15:0] CN [5] = '{16'h2, 16'h3, 16'h2, 16'h2, 16'h0202};
  localparam logic [31:0] ES [5] = '{32'h104, 32'h100, 32'hFE, 32'h100, 32'h104};
  localparam logic [31:0] ED [5] = '{32'h1FC, 32'h203, 32'h200, 32'h202, 32'h200};
  localparam int          EM [5] = '{2, 3, 2, 2, 4};
  dfa_channel u_dut (.*);
  dfa_bus_model u_bus (.i_clock, .i_rst, .i_xfer_valid(o_xfer_valid), .o_xfer_done(i_xfer_done),
    .o_pin(i_ext_request_pin), .o_preempt(i_bus_preempt), .o_timer_match(i_timer_match));
  initial forever #5 i_clock = ~i_clock;
  task test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge i_clock);
    i_awaddr <= a; i_wdata <= d; i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_clock);
      if (!aw_ok && o_awready === 1'b1) begin aw_ok = 1; i_awvalid <= 1'b0; end
      if (!w_ok && o_wready === 1'b1) begin w_ok = 1; i_wvalid <= 1'b0; end
    end
    do @(posedge i_clock); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk(32'(o_bresp), 32'(RESP_OKAY));
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clock);
    i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
    do @(posedge i_clock); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_clock); while (o_rvalid !== 1'b1);
    d = o_rdata; r = o_rresp; i_rready <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  // enable bits need a zero read between two writes
  task arm(input logic [7:0] a, input logic [7:0] v);
    wr(a, 32'h0);
    rchk(a, 32'h0);
    wr(a, 32'(v));
  endtask
  // move and interrupt tally, plus the hang limit
  always @(posedge i_clock) begin
    cyc++;
    if (o_xfer_valid === 1'b1 && i_xfer_done === 1'b1) begin
      moves++;
      chk(32'(o_xfer_word), 32'(ca_now[CA_SIZE]));
    end
    if (o_bus_hold === 1'b1) holds++;
    if (o_transfer_end_irq === 1'b1) irqs++;
    if (cyc == 30000) begin errors++; test_done(); end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    rchk(OFS_CTRL_A, 32'h0);
    rchk(OFS_CTRL_B, 32'h0);
    wr(OFS_CTRL_B, 32'h40);
    wr(OFS_CTRL_B, 32'hC0);
    rchk(OFS_CTRL_B, 32'h40);
    wr(OFS_CTRL_A, 32'h06);
    wr(OFS_CTRL_A, 32'h86);
    rchk(OFS_CTRL_A, 32'h06);
    rd(8'h1C, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    for (int k = 0; k < 5; k++) begin
      wr(OFS_SRC_ADDR, 32'h100);
      wr(OFS_DST_ADDR, 32'h200);
      wr(OFS_COUNT_A, 32'(CN[k]));
      wr(OFS_COUNT_B, (k == 4) ? 32'h2 : 32'h0);
      m0 = moves;
      i0 = irqs;
      h0 = holds;
      ca_now <= CA[k];
      arm(OFS_CTRL_B, CB[k]);
      arm(OFS_CTRL_A, CA[k]);
      for (int n = 0; n < 3000 && irqs == i0; n++) @(posedge i_clock);
      chk(moves - m0, EM[k]);
      chk(irqs, i0 + 1);
      chk(32'(holds > h0), 32'(k == 0));
      rchk(OFS_CTRL_A, 32'(CA[k] & 8'h7F));
      rchk(OFS_SRC_ADDR, ES[k]);
      rchk(OFS_DST_ADDR, ED[k]);
      rchk(OFS_COUNT_A, (k == 4) ? 32'h0202 : 32'h0);
      $display("test %0d done", k);
    end
    i_nmi <= 1'b1;
    @(posedge i_clock);
    i_nmi <= 1'b0;
    rchk(OFS_CTRL_B, 32'h10);
    i_standby <= 1'b1;
    @(posedge i_clock);
    i_standby <= 1'b0;
    rchk(OFS_CTRL_A, 32'h0);
    rchk(OFS_COUNT_A, 32'h0202);
    test_done();
  end
endmodule // tb_dfa_channel
